// ==== inc/reset_glitch_filter_control_map.vh ====
// What this block does
// - Power-on issues warm reset before boot starts
// - Watchdog reset drives reset pin low
// - Watchdog reset may go to CPU interrupt
// - Glitch filter always cleans reset pin input
// - Glitch filter has no software control
// - Undervoltage monitors raise interrupt or reset
`ifndef RESET_GLITCH_FILTER_CONTROL_MAP_VH
`define RESET_GLITCH_FILTER_CONTROL_MAP_VH
// Glitch filter hold time in ns and its cycle count
`define FILTER_HOLD_NS 100
`define CLK_PERIOD_NS 5
`define FILTER_CYCLES ((`FILTER_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Warm reset length in ns and its cycle count
`define WARM_RESET_NS 500
`define WARM_CYCLES ((`WARM_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Pin drive length in ns for a watchdog reset
`define PIN_DRIVE_NS 1000
`define PIN_CYCLES ((`PIN_DRIVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Counter width
`define CNT_W 8
`endif

// ==== core/reset_glitch_filter_control.v ====
`timescale 1ns/1ps
`default_nettype none
`include "reset_glitch_filter_control_map.vh"
module reset_glitch_filter_control (
  input wire mclk,
  input wire rst,
  input wire reset_pin_n_in,
  output wire reset_pin_n_out,
  output wire reset_pin_n_oe,
  input wire power_on_monitor,
  input wire brownout_monitor,
  input wire brownout_to_irq,
  input wire watchdog_reset,
  input wire watchdog_to_irq,
  output reg warm_reset,
  output reg boot_start,
  output reg watchdog_irq,
  output reg brownout_irq
);
  // States of the sequencer, one-hot
  // Warm: internal reset held, causes watched
  localparam [3:0] st_warm = 4'h1;
  // Boot: single cycle that releases boot
  localparam [3:0] st_boot = 4'h2;
  // Run: normal operation, causes watched
  localparam [3:0] st_run = 4'h4;
  // Drive: pin pulled low after watchdog reset
  localparam [3:0] st_drive = 4'h8;
  // Last counts as full integers, cut to counter width below
  localparam integer filter_end = `FILTER_CYCLES - 1;
  localparam integer warm_end = `WARM_CYCLES - 1;
  localparam integer pin_end = `PIN_CYCLES - 1;
  // Last filter count before a new level is taken
  localparam [`CNT_W-1:0] filter_max = filter_end[`CNT_W-1:0];
  // Last warm count before boot may start
  localparam [`CNT_W-1:0] warm_max = warm_end[`CNT_W-1:0];
  // Last drive count before the pin is released
  localparam [`CNT_W-1:0] pin_max = pin_end[`CNT_W-1:0];
  // Saturation value of the sequencer counter
  localparam [`CNT_W-1:0] cnt_top = {`CNT_W{1'h1}};
  // Zero value shared by both counters
  localparam [`CNT_W-1:0] cnt_zero = {`CNT_W{1'h0}};
  // Three stage pin synchroniser
  reg sync_a;
  reg sync_b;
  reg sync_c;
  // Filtered pin level, high means released
  reg pin_clean;
  // Stability counter of the filter
  reg [`CNT_W-1:0] filter_cnt;
  // Sequencer state and its counter
  reg [3:0] state;
  reg [3:0] next_state;
  reg [`CNT_W-1:0] seq_cnt;
  // Any reset cause that starts a warm reset
  wire cause_reset;
  // Watchdog reset routed as a real reset
  wire wd_hard;
  // Undervoltage routed as a real reset
  wire bo_hard;

  // Counter step shared by the filter and sequencer counters
  // Kept in one place so both counters step the same way
  function [`CNT_W-1:0] bump;
    input [`CNT_W-1:0] value;
    begin
      // Add one at the counter width, no carry kept
      bump = value + {{(`CNT_W-1){1'h0}}, 1'h1};
    end
  endfunction

  // Synchroniser chain; first flop feeds only the second
  always @(posedge mclk)
  begin
    if (rst)
    begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      sync_c <= 1'b1;
    end
    else
    begin
      sync_a <= reset_pin_n_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Fixed glitch filter, no control input exists
  // Counts only while second and third flops agree
  // A level that bounces restarts the count, so spikes never pass
  // Pin drive by this block is read back through the same path
  always @(posedge mclk)
  begin
    if (rst)
    begin
      pin_clean <= 1'b1;
      filter_cnt <= {`CNT_W{1'b0}};
    end
    else if ((sync_b != sync_c) || (sync_c == pin_clean))
    begin
      // Unstable or unchanged, restart the count
      filter_cnt <= cnt_zero;
    end
    else if (filter_cnt == filter_max)
    begin
      // Held long enough, accept new level
      pin_clean <= sync_c;
      filter_cnt <= cnt_zero;
    end
    else
    begin
      // Stable new level, keep counting
      filter_cnt <= bump(filter_cnt);
    end
  end

  // Watchdog goes to reset unless routed as interrupt
  assign wd_hard = watchdog_reset & ~watchdog_to_irq;
  // Undervoltage goes to reset unless routed as interrupt
  assign bo_hard = brownout_monitor & ~brownout_to_irq;
  // Filtered pin held low counts as reset
  assign cause_reset = power_on_monitor | bo_hard | ~pin_clean;

  // Next state logic
  // Reset causes beat the watchdog in run
  // Boot always lasts one cycle, causes then act from run
  always @*
  begin
    next_state = state;
    case (state)
      st_warm:
        // Hold warm reset until causes clear and time runs out
        if (!cause_reset && seq_cnt == warm_max)
          next_state = st_boot;
      st_boot:
        // Boot released, go on to run
        next_state = st_run;
      st_run:
        if (cause_reset)
          next_state = st_warm;
        else if (wd_hard)
          next_state = st_drive;
      st_drive:
        // Causes are ignored while the pin is driven
        if (seq_cnt == pin_max)
          next_state = st_warm;
      default:
        // Illegal code, fall back to warm reset
        next_state = st_warm;
    endcase
  end

  // State register and counter
  // Counter restarts on each state change
  // A live cause in warm restarts the warm time as well
  always @(posedge mclk)
  begin
    if (rst)
    begin
      // Start in warm reset with a fresh count
      state <= st_warm;
      seq_cnt <= cnt_zero;
    end
    else
    begin
      state <= next_state;
      if (next_state != state || (state == st_warm && cause_reset))
        // New phase or cause still present
        seq_cnt <= cnt_zero;
      else if (seq_cnt != cnt_top)
        // Count up, stop at the top value
        seq_cnt <= bump(seq_cnt);
    end
  end

  // Registered outputs
  // Warm and boot taken from the next state so they line up with the state
  always @(posedge mclk)
  begin
    if (rst)
    begin
      warm_reset <= 1'b1;
      boot_start <= 1'b0;
      watchdog_irq <= 1'b0;
      brownout_irq <= 1'b0;
    end
    else
    begin
      // Warm reset covers warm and pin drive phases
      warm_reset <= (next_state == st_warm) || (next_state == st_drive);
      // One-cycle boot pulse after warm reset ends
      boot_start <= (next_state == st_boot);
      // Watchdog redirected as interrupt level, held while watchdog_reset stays high in run
      watchdog_irq <= (state == st_run) && watchdog_reset && watchdog_to_irq;
      // Undervoltage redirected as interrupt level
      brownout_irq <= brownout_monitor && brownout_to_irq;
    end
  end

  // Open-drain style drive: low only during watchdog reset
  // The pin is never driven high, the outside pull-up does that
  assign reset_pin_n_out = 1'b0;
  assign reset_pin_n_oe = (state == st_drive);
endmodule
`default_nettype wire

// ==== testbench/ext_reset_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module ext_reset_source (
  input wire logic drive_low,
  input wire logic hold_low,
  output wire logic pin_n
);
  // Pull-up wins unless the device or the supervisor pulls low
  assign pin_n = (drive_low || hold_low) ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

// ==== testbench/rgfc_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module rgfc_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_pin_n_oe,
  input wire logic power_on_monitor,
  input wire logic brownout_monitor,
  input wire logic brownout_to_irq,
  input wire logic watchdog_reset,
  input wire logic watchdog_to_irq,
  input wire logic warm_reset,
  input wire logic boot_start,
  input wire logic watchdog_irq,
  input wire logic brownout_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_boot_ends_warm: assert property (boot_start |-> $past(warm_reset) && !warm_reset)
    else $error("boot start without warm end");
  a_boot_one_cycle: assert property (boot_start |=> !boot_start)
    else $error("boot start too long");
  a_drive_in_warm: assert property (reset_pin_n_oe |-> warm_reset)
    else $error("pin driven outside warm reset");
  a_drive_holds: assert property ($rose(reset_pin_n_oe) |-> reset_pin_n_oe[*8])
    else $error("pin drive too short");
  a_watchdog_drives: assert property (watchdog_reset && !watchdog_to_irq && !warm_reset && !boot_start && !power_on_monitor && !(brownout_monitor && !brownout_to_irq) |=> reset_pin_n_oe)
    else $error("watchdog did not drive pin");
  a_watchdog_irq: assert property (watchdog_reset && watchdog_to_irq && !warm_reset && !boot_start |=> watchdog_irq && !reset_pin_n_oe)
    else $error("watchdog interrupt not routed");
  a_brownout_irq: assert property (brownout_monitor && brownout_to_irq |=> brownout_irq)
    else $error("undervoltage interrupt missing");
  a_brownout_reset: assert property (brownout_monitor && !brownout_to_irq |-> ##[1:3] warm_reset)
    else $error("undervoltage reset missing");
endmodule
bind reset_glitch_filter_control rgfc_sva chk (.*);
`default_nettype wire

// ==== testbench/reset_glitch_filter_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "reset_glitch_filter_control_map.vh"
module reset_glitch_filter_control_test;
  logic mclk = 1'h0, rst = 1'h1, hold_low = 1'h0, power_on_monitor = 1'h0, brownout_monitor = 1'h0;
  logic brownout_to_irq = 1'h0, watchdog_reset = 1'h0, watchdog_to_irq = 1'h0;
  wire reset_pin_n_in, reset_pin_n_out, reset_pin_n_oe, warm_reset, boot_start, watchdog_irq;
  wire brownout_irq;
  int num_errors = 0, checks_done = 0, n;
  always #2.5 mclk = ~mclk;
  reset_glitch_filter_control dut (.*);
  ext_reset_source src (.drive_low(reset_pin_n_oe), .hold_low(hold_low), .pin_n(reset_pin_n_in));
  task cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task chk(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Bounded wait for the boot pulse, n counts cycles
  task wait_boot;
    n = 0;
    while (boot_start !== 1'h1 && n < 2000)
    begin
      cyc(1);
      n++;
    end
    chk("boot_start", 1'h1, boot_start);
    chk("warm_reset", 1'h0, warm_reset);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task test_power_up;
    cyc(16);
    rst = 1'h0;
    wait_boot;
    chk("warm_len", 1'h1, n >= `WARM_CYCLES);
    $display("test power_up done");
  endtask
  // Short low pulse is ignored, a long one resets
  task test_glitch;
    hold_low = 1'h1;
    cyc(10);
    hold_low = 1'h0;
    cyc(40);
    chk("glitch", 1'h0, warm_reset);
    hold_low = 1'h1;
    cyc(30);
    chk("held_low", 1'h1, warm_reset);
    hold_low = 1'h0;
    wait_boot;
    $display("test glitch done");
  endtask
  // Watchdog routed to interrupt, then as hard reset
  task test_watchdog;
    watchdog_to_irq = 1'h1;
    watchdog_reset = 1'h1;
    cyc(2);
    chk("wd_irq", 1'h1, watchdog_irq);
    chk("wd_no_drive", 1'h0, reset_pin_n_oe);
    watchdog_to_irq = 1'h0;
    cyc(1);
    watchdog_reset = 1'h0;
    chk("pin_low", 1'h0, reset_pin_n_in);
    chk("pin_out", 1'h0, reset_pin_n_out);
    for (n = 0; reset_pin_n_oe === 1'h1 && n < 1000; n++)
      cyc(1);
    chk("drive_len", 1'h1, n == `PIN_CYCLES);
    wait_boot;
    $display("test watchdog done");
  endtask
  // Undervoltage as interrupt, then as reset
  task test_brownout;
    brownout_to_irq = 1'h1;
    brownout_monitor = 1'h1;
    cyc(2);
    chk("bor_irq", 1'h1, brownout_irq);
    brownout_to_irq = 1'h0;
    cyc(3);
    chk("bor_reset", 1'h1, warm_reset);
    brownout_monitor = 1'h0;
    wait_boot;
    $display("test brownout done");
  endtask
  // Power-on cause holds warm reset, boot only after it clears
  task test_power_on;
    power_on_monitor = 1'h1;
    cyc(2);
    chk("por_reset", 1'h1, warm_reset);
    cyc(150);
    chk("por_held", 1'h1, warm_reset);
    chk("por_no_boot", 1'h0, boot_start);
    power_on_monitor = 1'h0;
    wait_boot;
    $display("test power_on done");
  endtask
  // Reset again in mid-run, then a fresh warm phase
  task test_mid_reset;
    rst = 1'h1;
    cyc(16);
    chk("rst_warm", 1'h1, warm_reset);
    chk("rst_no_drive", 1'h0, reset_pin_n_oe);
    rst = 1'h0;
    wait_boot;
    chk("rst_warm_len", 1'h1, n >= `WARM_CYCLES);
    $display("test mid_reset done");
  endtask
  initial
  begin
    test_power_up;
    test_glitch;
    test_watchdog;
    test_brownout;
    test_power_on;
    test_mid_reset;
    wrap_up;
  end
  initial
  begin
    #50000;
    num_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
